// ==== design/rpp_cfg.svh ====
// Purpose: constants of the reverse power stage
// Assumes: 125 MHz clock, 32-bit classic Wishbone
// Notes: powers and pick-up in 0.01 kW, delays in 5 ms ticks
`ifndef RPP_CFG_SVH
`define RPP_CFG_SVH
`define RPP_CLK_HZ          125000000
`define RPP_STAMP_MS        1
`define RPP_CYC_PER_MS      (`RPP_CLK_HZ / 1000 * `RPP_STAMP_MS)
`define RPP_CYCLE_MS        5
`define RPP_CYCLE_LAST      3'h4
`define RPP_PRE_TRIG_MS     20
`define RPP_PRE_FAULT_MS    200
`define RPP_PRE_TRIG_BACK   6'((`RPP_PRE_TRIG_MS / `RPP_CYCLE_MS) + 1)
`define RPP_PRE_FAULT_BACK  6'((`RPP_PRE_FAULT_MS / `RPP_CYCLE_MS) + 1)
`define RPP_PSET_MIN        32'h00000001
`define RPP_PSET_MAX        32'h00989680
`define RPP_PSET_DEF        24'h002710
`define RPP_DLY_MAX         32'h00057E40
`define RPP_OPD_DEF         20'h000C8
`define RPP_RSD_DEF         20'h00000
`define RPP_RATIO_PICK      17'h00064
`define RPP_RATIO_HYST      17'h00061
`define RPP_RATIO_MAX       40'h000001E848
`define RPP_PCT             40'h0000000064
`define RPP_REC_LAST        4'hB
`define RPP_EVT_MASK_DEF    6'h3F
`define RPP_CTRL_MASK       32'h00000777
`define RPP_ADR_CTRL        8'h00
`define RPP_ADR_PSET        8'h04
`define RPP_ADR_OPD         8'h08
`define RPP_ADR_RSD         8'h0C
`define RPP_ADR_STATUS      8'h10
`define RPP_ADR_RATIO       8'h14
`define RPP_ADR_EXPECT      8'h18
`define RPP_ADR_REMAIN      8'h1C
`define RPP_ADR_CNT_START   8'h20
`define RPP_ADR_CNT_TRIP    8'h24
`define RPP_ADR_CNT_BLK     8'h28
`define RPP_ADR_EVT_MASK    8'h2C
`define RPP_ADR_REC_SEL     8'h30
`define RPP_ADR_REC_DATA    8'h34
`define RPP_ADR_TIME        8'h38
`define RPP_CTRL_FORCE_EN   0
`define RPP_CTRL_FORCE_LSB  1
`define RPP_CTRL_GRP_LSB    4
`define RPP_CTRL_EDIT_LSB   8
`define RPP_REC_FLD_LSB     4
`endif

// ==== design/rpp_pkg.sv ====
// Purpose: types of the reverse power stage
// Assumes: nothing
// Notes: state codes step one bit from normal to start to trip, two bits back to normal
package rpp_pkg;
	typedef enum logic [2:0] {
		ST_NORMAL  = 3'h0,
		ST_START   = 3'h1,
		ST_TRIP    = 3'h3,
		ST_RELEASE = 3'h5,
		ST_BLOCKED = 3'h4
	} rpp_state_t;
	typedef enum logic [1:0] {
		COND_NORMAL  = 2'h0,
		COND_START   = 2'h1,
		COND_TRIP    = 2'h2,
		COND_BLOCKED = 2'h3
	} rpp_cond_t;
endpackage

// ==== design/rpp_stage.sv ====
// Purpose: one reverse active power protection stage with event log
// Assumes: measurement and blocking inputs come from logic on clk_in
// Notes: registers over classic Wishbone, ack one cycle after request
// What this block does
// RULE_01: consume phase current and voltage magnitudes each 5 ms
// RULE_02: forcing overrides condition, default normal
// RULE_03: ratio of power to pick-up decides pick-up
// RULE_04: release below 97 percent of pick-up
// RULE_05: pick-up 0.01 to 100000 kW, default 100
// RULE_06: setting group switches live without stopping
// RULE_07: condition readable in real time
// RULE_08: report expected and remaining time, 5 ms
// RULE_09: report power ratio in 0.01 steps
// RULE_10: sample blocking input at cycle start
// RULE_11: pick-up unblocked gives start and timing
// RULE_12: pick-up while blocked gives blocked only
// RULE_13: blocking during start drops start, runs release
// RULE_14: blocking arrives 5 ms before operate delay
// RULE_15: definite time only for trip and reset
// RULE_16: masked time-stamped on and off events
// RULE_17: time stamps in one millisecond steps
// RULE_18: resettable counters for start, trip, blocked
// RULE_19: exactly one independent stage
// RULE_20: keep newest twelve records, overwrite oldest
// RULE_21: record time, event, powers, remaining, group
// RULE_22: trip after operate delay, clear after reset
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "rpp_cfg.svh"
module rpp_stage #(
	parameter int CYC_PER_MS = `RPP_CYC_PER_MS
) (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               wb_cyc_in,
	input  wire logic               wb_stb_in,
	input  wire logic               wb_we_in,
	input  wire logic [7:0]         wb_adr_in,
	input  wire logic [3:0]         wb_sel_in,
	input  wire logic [31:0]        wb_dat_in,
	output logic      [31:0]        wb_dat_out,
	output logic                    wb_ack_out,
	input  wire logic [15:0]        i_l1_in,
	input  wire logic [15:0]        i_l2_in,
	input  wire logic [15:0]        i_l3_in,
	input  wire logic [15:0]        u1_in,
	input  wire logic [15:0]        u2_in,
	input  wire logic [15:0]        u3_in,
	input  wire logic [15:0]        u4_in,
	input  wire logic signed [31:0] measured_active_power_in,
	input  wire logic               block_in,
	output logic                    start_out,
	output logic                    trip_out,
	output logic                    blocked_out,
	output logic      [1:0]         cond_out,
	output logic                    evt_valid_out,
	output logic      [2:0]         evt_code_out,
	output logic      [31:0]        evt_time_out
);
	localparam logic [16:0] MS_LAST = 17'(CYC_PER_MS - 1);
	localparam logic [16:0] RATIO_CAP = 17'(`RPP_RATIO_MAX);

	function automatic logic [16:0] ratio_f(input logic [31:0] rev, input logic [23:0] pset);
		logic [39:0] q;
		begin
			q = ({8'h00, rev} * `RPP_PCT) / {16'h0000, pset};
			ratio_f = (q > `RPP_RATIO_MAX) ? RATIO_CAP : q[16:0];
		end
	endfunction

	function automatic logic [31:0] sel_f(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		begin
			sel_f = old;
			for (int i = 0; i < 4; i++)
			begin
				if (sel[i])
					sel_f[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction

	function automatic logic [31:0] clamp_f(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		begin
			clamp_f = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	// time bases
	logic [16:0] ms_div_r;
	logic [2:0]  cyc_div_r;
	logic        ms_tick;
	logic        cycle_tick;
	logic [31:0] time_ms_r;
	// bus
	logic        req;
	logic        ack_r;
	logic        wr_now;
	logic [31:0] dat_r;
	logic [31:0] rd_mux;
	// settings
	logic [31:0] ctrl_r;
	logic [23:0] pset_mem [0:7];
	logic [19:0] opd_mem  [0:7];
	logic [19:0] rsd_mem  [0:7];
	logic [5:0]  evt_mask_r;
	logic [6:0]  rec_sel_r;
	logic        force_en;
	rpp_pkg::rpp_cond_t force_sel;
	logic [2:0]  grp;
	logic [2:0]  edit;
	logic [23:0] pset_a;
	logic [19:0] opd_a;
	logic [19:0] rsd_a;
	logic [31:0] pset_wv;
	logic [31:0] opd_wv;
	logic [31:0] rsd_wv;
	// evaluation
	logic        meas_ok;
	logic [31:0] rev;
	logic [16:0] ratio_now;
	logic        blk_s;
	logic        picked_nxt;
	logic        picked_r;
	logic [16:0] ratio_r;
	logic signed [31:0] pow_r;
	rpp_pkg::rpp_state_t state_r;
	logic [19:0] op_cnt_r;
	logic [19:0] rel_cnt_r;
	logic [19:0] remain;
	rpp_pkg::rpp_cond_t cond_nxt;
	rpp_pkg::rpp_cond_t cond_r;
	logic        start_r;
	logic        trip_r;
	logic        blk_r;
	// events and records
	logic [5:0]  ev_set;
	logic [5:0]  pend_r;
	logic [5:0]  grant;
	logic [2:0]  grant_code;
	logic        evt_valid_r;
	logic [2:0]  evt_code_r;
	logic [31:0] evt_time_r;
	logic [31:0] cnt_start_r;
	logic [31:0] cnt_trip_r;
	logic [31:0] cnt_blk_r;
	logic        clr_start;
	logic        clr_trip;
	logic        clr_blk;
	logic signed [31:0] hist [0:63];
	logic [5:0]  hp_r;
	logic signed [31:0] pf_hold_r;
	logic        rec_wr;
	logic [3:0]  rec_wp_r;
	logic [31:0] rec_time [0:11];
	logic [5:0]  rec_tag  [0:11];
	logic signed [31:0] rec_pre [0:11];
	logic signed [31:0] rec_flt [0:11];
	logic signed [31:0] rec_pf  [0:11];
	logic [19:0] rec_rem  [0:11];
	logic [3:0]  rs;

	// 1 ms stamp tick and 5 ms cycle tick
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			ms_div_r <= 17'h00000;
		else if (ms_tick)
			ms_div_r <= 17'h00000;
		else
			ms_div_r <= ms_div_r + 17'h00001;
	end
	assign ms_tick = (ms_div_r == MS_LAST);
	assign cycle_tick = ms_tick && (cyc_div_r == `RPP_CYCLE_LAST);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cyc_div_r <= 3'h0;
		else if (cycle_tick)
			cyc_div_r <= 3'h0;
		else if (ms_tick)
			cyc_div_r <= cyc_div_r + 3'h1;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			time_ms_r <= 32'h00000000;
		else if (wr_now && wb_adr_in == `RPP_ADR_TIME)
			time_ms_r <= sel_f(time_ms_r, wb_dat_in, wb_sel_in);
		else if (ms_tick)
			time_ms_r <= time_ms_r + 32'h00000001; // RULE_17
	end

	// wishbone slave, write takes effect on the ack edge
	assign req = wb_cyc_in && wb_stb_in;
	assign wr_now = req && wb_we_in && ack_r;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end
		else
		begin
			ack_r <= req && !ack_r;
			if (req && !ack_r)
				dat_r <= rd_mux;
		end
	end
	assign wb_ack_out = ack_r;
	assign wb_dat_out = dat_r;

	assign rs = rec_sel_r[3:0];
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (wb_adr_in == `RPP_ADR_CTRL)
			rd_mux = ctrl_r;
		else if (wb_adr_in == `RPP_ADR_PSET)
			rd_mux = {8'h00, pset_mem[edit]};
		else if (wb_adr_in == `RPP_ADR_OPD)
			rd_mux = {12'h000, opd_mem[edit]};
		else if (wb_adr_in == `RPP_ADR_RSD)
			rd_mux = {12'h000, rsd_mem[edit]};
		else if (wb_adr_in == `RPP_ADR_STATUS)
			rd_mux = {20'h00000, rec_wp_r, 1'b0, picked_r, cond_r, blk_r, trip_r, start_r}; // RULE_07
		else if (wb_adr_in == `RPP_ADR_RATIO)
			rd_mux = {15'h0000, ratio_r}; // RULE_09
		else if (wb_adr_in == `RPP_ADR_EXPECT)
			rd_mux = {12'h000, opd_a}; // RULE_08
		else if (wb_adr_in == `RPP_ADR_REMAIN)
			rd_mux = {12'h000, remain}; // RULE_08
		else if (wb_adr_in == `RPP_ADR_CNT_START)
			rd_mux = cnt_start_r;
		else if (wb_adr_in == `RPP_ADR_CNT_TRIP)
			rd_mux = cnt_trip_r;
		else if (wb_adr_in == `RPP_ADR_CNT_BLK)
			rd_mux = cnt_blk_r;
		else if (wb_adr_in == `RPP_ADR_EVT_MASK)
			rd_mux = {26'h0000000, evt_mask_r};
		else if (wb_adr_in == `RPP_ADR_REC_SEL)
			rd_mux = {25'h0000000, rec_sel_r};
		else if (wb_adr_in == `RPP_ADR_REC_DATA && rs <= `RPP_REC_LAST)
		begin
			case (rec_sel_r[6:4])
				3'h0: rd_mux = rec_time[rs];
				3'h1: rd_mux = {26'h0000000, rec_tag[rs]};
				3'h2: rd_mux = rec_pre[rs];
				3'h3: rd_mux = rec_flt[rs];
				3'h4: rd_mux = rec_pf[rs];
				3'h5: rd_mux = {12'h000, rec_rem[rs]};
				default: rd_mux = 32'h00000000;
			endcase
		end
		else if (wb_adr_in == `RPP_ADR_TIME)
			rd_mux = time_ms_r;
	end

	// settings, group banks edited and selected independently
	assign force_en = ctrl_r[`RPP_CTRL_FORCE_EN];
	assign force_sel = rpp_pkg::rpp_cond_t'(ctrl_r[`RPP_CTRL_FORCE_LSB +: 2]);
	assign grp = ctrl_r[`RPP_CTRL_GRP_LSB +: 3];
	assign edit = ctrl_r[`RPP_CTRL_EDIT_LSB +: 3];
	assign pset_a = pset_mem[grp]; // RULE_06
	assign opd_a = opd_mem[grp];
	assign rsd_a = rsd_mem[grp];
	assign pset_wv = clamp_f(sel_f({8'h00, pset_mem[edit]}, wb_dat_in, wb_sel_in),
		`RPP_PSET_MIN, `RPP_PSET_MAX); // RULE_05
	assign opd_wv = clamp_f(sel_f({12'h000, opd_mem[edit]}, wb_dat_in, wb_sel_in),
		`RPP_PSET_MIN, `RPP_DLY_MAX);
	assign rsd_wv = clamp_f(sel_f({12'h000, rsd_mem[edit]}, wb_dat_in, wb_sel_in),
		32'h00000000, `RPP_DLY_MAX);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl_r <= 32'h00000000; // RULE_02
			evt_mask_r <= `RPP_EVT_MASK_DEF;
			rec_sel_r <= 7'h00;
			for (int g = 0; g < 8; g++)
			begin
				pset_mem[g] <= `RPP_PSET_DEF; // RULE_05
				opd_mem[g] <= `RPP_OPD_DEF;
				rsd_mem[g] <= `RPP_RSD_DEF;
			end
		end
		else if (wr_now)
		begin
			if (wb_adr_in == `RPP_ADR_CTRL)
				ctrl_r <= sel_f(ctrl_r, wb_dat_in, wb_sel_in) & `RPP_CTRL_MASK;
			else if (wb_adr_in == `RPP_ADR_PSET)
				pset_mem[edit] <= pset_wv[23:0];
			else if (wb_adr_in == `RPP_ADR_OPD)
				opd_mem[edit] <= opd_wv[19:0];
			else if (wb_adr_in == `RPP_ADR_RSD)
				rsd_mem[edit] <= rsd_wv[19:0];
			else if (wb_adr_in == `RPP_ADR_EVT_MASK && wb_sel_in[0])
				evt_mask_r <= wb_dat_in[5:0];
			else if (wb_adr_in == `RPP_ADR_REC_SEL && wb_sel_in[0])
				rec_sel_r <= wb_dat_in[6:0];
		end
	end

	// pick-up evaluation on each 5 ms cycle
	assign meas_ok = (|{i_l1_in, i_l2_in, i_l3_in}) && (|{u1_in, u2_in, u3_in, u4_in}); // RULE_01
	assign rev = (meas_ok && measured_active_power_in < 0) ?
		32'(-measured_active_power_in) : 32'h00000000;
	assign ratio_now = ratio_f(rev, pset_a); // RULE_03
	assign blk_s = block_in; // RULE_10
	assign picked_nxt = picked_r ? (ratio_now >= `RPP_RATIO_HYST) : // RULE_04
		(ratio_now >= `RPP_RATIO_PICK); // RULE_03

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			picked_r <= 1'b0;
			ratio_r <= 17'h00000;
			pow_r <= 32'sh00000000;
		end
		else if (cycle_tick)
		begin
			picked_r <= picked_nxt;
			ratio_r <= ratio_now; // RULE_09
			pow_r <= meas_ok ? measured_active_power_in : 32'sh00000000; // RULE_01
		end
	end

	// definite time operate and reset state machine, single stage
	always_ff @(posedge clk_in or posedge rst_in) // RULE_19
	begin
		if (rst_in)
		begin
			state_r <= rpp_pkg::ST_NORMAL;
			op_cnt_r <= 20'h00000;
			rel_cnt_r <= 20'h00000;
		end
		else if (cycle_tick)
		begin
			case (state_r)
				rpp_pkg::ST_NORMAL:
				begin
					op_cnt_r <= 20'h00000;
					rel_cnt_r <= 20'h00000;
					if (picked_nxt && blk_s)
						state_r <= rpp_pkg::ST_BLOCKED; // RULE_12
					else if (picked_nxt)
						state_r <= rpp_pkg::ST_START; // RULE_11
				end
				rpp_pkg::ST_START:
				begin
					rel_cnt_r <= 20'h00000;
					if (picked_nxt && !blk_s)
					begin
						op_cnt_r <= op_cnt_r + 20'h00001; // RULE_15
						if (op_cnt_r + 20'h00001 >= opd_a)
							state_r <= rpp_pkg::ST_TRIP; // RULE_22
					end
					else
						state_r <= rpp_pkg::ST_RELEASE; // RULE_13
				end
				rpp_pkg::ST_RELEASE:
				begin
					if (picked_nxt && !blk_s)
						state_r <= rpp_pkg::ST_START;
					else if (rel_cnt_r >= rsd_a)
						state_r <= rpp_pkg::ST_NORMAL; // RULE_15
					else
						rel_cnt_r <= rel_cnt_r + 20'h00001;
				end
				rpp_pkg::ST_TRIP:
				begin
					if (picked_nxt && !blk_s)
						rel_cnt_r <= 20'h00000;
					else if (rel_cnt_r >= rsd_a)
						state_r <= rpp_pkg::ST_NORMAL; // RULE_22
					else
						rel_cnt_r <= rel_cnt_r + 20'h00001;
				end
				rpp_pkg::ST_BLOCKED:
				begin
					if (!picked_nxt)
						state_r <= rpp_pkg::ST_NORMAL;
					else if (!blk_s)
						state_r <= rpp_pkg::ST_START;
				end
				default: state_r <= rpp_pkg::ST_NORMAL;
			endcase
		end
	end

	assign remain = (state_r == rpp_pkg::ST_START || state_r == rpp_pkg::ST_RELEASE) ?
		((op_cnt_r < opd_a) ? opd_a - op_cnt_r : 20'h00000) : 20'h00000; // RULE_08

	// condition with forcing override
	always_comb
	begin
		if (force_en)
			cond_nxt = force_sel; // RULE_02
		else if (state_r == rpp_pkg::ST_START)
			cond_nxt = rpp_pkg::COND_START;
		else if (state_r == rpp_pkg::ST_TRIP)
			cond_nxt = rpp_pkg::COND_TRIP;
		else if (state_r == rpp_pkg::ST_BLOCKED)
			cond_nxt = rpp_pkg::COND_BLOCKED;
		else
			cond_nxt = rpp_pkg::COND_NORMAL;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cond_r <= rpp_pkg::COND_NORMAL;
			start_r <= 1'b0;
			trip_r <= 1'b0;
			blk_r <= 1'b0;
		end
		else
		begin
			cond_r <= cond_nxt; // RULE_07
			start_r <= (cond_nxt == rpp_pkg::COND_START);
			trip_r <= (cond_nxt == rpp_pkg::COND_TRIP);
			blk_r <= (cond_nxt == rpp_pkg::COND_BLOCKED);
		end
	end
	assign start_out = start_r;
	assign trip_out = trip_r;
	assign blocked_out = blk_r;
	assign cond_out = cond_r;

	// events: bit i is code i, on then off for start, trip, block
	assign ev_set[0] = (cond_nxt == rpp_pkg::COND_START) && !start_r;
	assign ev_set[1] = (cond_nxt != rpp_pkg::COND_START) && start_r;
	assign ev_set[2] = (cond_nxt == rpp_pkg::COND_TRIP) && !trip_r;
	assign ev_set[3] = (cond_nxt != rpp_pkg::COND_TRIP) && trip_r;
	assign ev_set[4] = (cond_nxt == rpp_pkg::COND_BLOCKED) && !blk_r;
	assign ev_set[5] = (cond_nxt != rpp_pkg::COND_BLOCKED) && blk_r;
	assign grant = pend_r & (~pend_r + 6'h01);
	always_comb
	begin
		grant_code = 3'h0;
		for (int b = 5; b >= 0; b--)
		begin
			if (grant[b])
				grant_code = 3'(b);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pend_r <= 6'h00;
			evt_valid_r <= 1'b0;
			evt_code_r <= 3'h0;
			evt_time_r <= 32'h00000000;
		end
		else
		begin
			pend_r <= (pend_r & ~grant) | (ev_set & evt_mask_r); // RULE_16
			evt_valid_r <= |pend_r;
			evt_code_r <= grant_code;
			evt_time_r <= time_ms_r; // RULE_17
		end
	end
	assign evt_valid_out = evt_valid_r;
	assign evt_code_out = evt_code_r;
	assign evt_time_out = evt_time_r;

	// cumulative counters, each cleared by any write to its own address, a count in the clearing cycle leaves 1
	assign clr_start = wr_now && wb_adr_in == `RPP_ADR_CNT_START;
	assign clr_trip = wr_now && wb_adr_in == `RPP_ADR_CNT_TRIP;
	assign clr_blk = wr_now && wb_adr_in == `RPP_ADR_CNT_BLK;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_start_r <= 32'h00000000;
			cnt_trip_r <= 32'h00000000;
			cnt_blk_r <= 32'h00000000;
		end
		else
		begin
			cnt_start_r <= (clr_start ? 32'h00000000 : cnt_start_r) + {31'h0, ev_set[0]}; // RULE_18
			cnt_trip_r <= (clr_trip ? 32'h00000000 : cnt_trip_r) + {31'h0, ev_set[2]}; // RULE_18
			cnt_blk_r <= (clr_blk ? 32'h00000000 : cnt_blk_r) + {31'h0, ev_set[4]}; // RULE_18
		end
	end

	// power history and twelve-slot fault record ring
	assign rec_wr = ev_set[0] || ev_set[2] || ev_set[4];
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			hp_r <= 6'h00;
			pf_hold_r <= 32'sh00000000;
			rec_wp_r <= 4'h0;
		end
		else
		begin
			if (cycle_tick)
				hp_r <= hp_r + 6'h01;
			if (ev_set[0])
				pf_hold_r <= hist[hp_r - `RPP_PRE_FAULT_BACK];
			if (rec_wr)
				rec_wp_r <= (rec_wp_r == `RPP_REC_LAST) ? 4'h0 : rec_wp_r + 4'h1; // RULE_20
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (cycle_tick)
			hist[hp_r] <= meas_ok ? measured_active_power_in : 32'sh00000000;
		if (rec_wr)
		begin
			rec_time[rec_wp_r] <= time_ms_r; // RULE_21
			rec_tag[rec_wp_r] <= {grp, ev_set[4] ? 3'h4 : (ev_set[2] ? 3'h2 : 3'h0)};
			rec_pre[rec_wp_r] <= hist[hp_r - `RPP_PRE_TRIG_BACK];
			rec_flt[rec_wp_r] <= pow_r;
			rec_pf[rec_wp_r] <= ev_set[0] ? hist[hp_r - `RPP_PRE_FAULT_BACK] : pf_hold_r;
			rec_rem[rec_wp_r] <= remain;
		end
	end

	// checks
	property p_start_on_pick;
		@(posedge clk_in) disable iff (rst_in)
		(cycle_tick && state_r == rpp_pkg::ST_NORMAL && picked_nxt && !blk_s)
			|=> (state_r == rpp_pkg::ST_START);
	endproperty
	a_start_on_pick: assert property (p_start_on_pick) else $error("no start"); // RULE_11
	property p_block_on_pick;
		@(posedge clk_in) disable iff (rst_in)
		(cycle_tick && state_r == rpp_pkg::ST_NORMAL && picked_nxt && blk_s && !force_en)
			|=> (state_r == rpp_pkg::ST_BLOCKED) && !start_r;
	endproperty
	a_block_on_pick: assert property (p_block_on_pick) else $error("no block"); // RULE_12
	property p_block_drops_start;
		@(posedge clk_in) disable iff (rst_in)
		(cycle_tick && state_r == rpp_pkg::ST_START && blk_s)
			|=> (state_r == rpp_pkg::ST_RELEASE);
	endproperty
	a_block_drops_start: assert property (p_block_drops_start) else $error("start kept"); // RULE_13
	property p_trip_after_delay;
		@(posedge clk_in) disable iff (rst_in)
		$rose(state_r == rpp_pkg::ST_TRIP) |-> ($past(state_r) == rpp_pkg::ST_START)
			&& ($past(op_cnt_r) + 20'h00001 >= opd_a);
	endproperty
	a_trip_after_delay: assert property (p_trip_after_delay) else $error("early trip"); // RULE_22
	property p_hold_above_hyst;
		@(posedge clk_in) disable iff (rst_in)
		(cycle_tick && picked_r && ratio_now >= `RPP_RATIO_HYST) |=> picked_r;
	endproperty
	a_hold_above_hyst: assert property (p_hold_above_hyst) else $error("early drop"); // RULE_04
	property p_no_pick_below;
		@(posedge clk_in) disable iff (rst_in)
		(cycle_tick && !picked_r && ratio_now < `RPP_RATIO_PICK) |=> !picked_r ##1 !picked_r;
	endproperty
	a_no_pick_below: assert property (p_no_pick_below) else $error("false pick"); // RULE_03
	property p_rec_wrap;
		@(posedge clk_in) disable iff (rst_in)
		(rec_wr && rec_wp_r == `RPP_REC_LAST) |=> (rec_wp_r == 4'h0);
	endproperty
	a_rec_wrap: assert property (p_rec_wrap) else $error("ring not wrapped"); // RULE_20
	property p_cnt_start;
		@(posedge clk_in) disable iff (rst_in)
		(ev_set[0] && !clr_start) |=> (cnt_start_r == $past(cnt_start_r) + 32'h00000001);
	endproperty
	a_cnt_start: assert property (p_cnt_start) else $error("start not counted"); // RULE_18
	property p_force;
		@(posedge clk_in) disable iff (rst_in)
		force_en |=> (cond_r == $past(force_sel)) && (trip_r == (cond_r == rpp_pkg::COND_TRIP));
	endproperty
	a_force: assert property (p_force) else $error("force ignored"); // RULE_02
endmodule

// ==== test/rpp_far_end.sv ====
// Purpose: measurement chain and blocking matrix beside the stage
// Assumes: commands from the bench, same clock
// Notes: outputs change just after a rising edge
`timescale 1ns/1ns
module rpp_far_end (
	input  wire logic               clk_in,
	input  wire logic signed [31:0] pwr_cmd_in,
	input  wire logic               blk_cmd_in,
	output logic      [15:0]        mag_out,
	output logic signed [31:0]      pwr_out,
	output logic                    blk_out
);
	// nonzero magnitudes so power counts
	assign mag_out = 16'h0100;
	always_ff @(posedge clk_in)
	begin
		pwr_out <= pwr_cmd_in;
		// block follows the command one clock later
		blk_out <= blk_cmd_in;
	end
endmodule

// ==== test/rpp_stage_test.sv ====
// Purpose: register and protection sequences for the stage
// Assumes: 10 clocks per ms, 5 ms tick of 50 clocks
// Notes: reverse power is negative at the power input
`timescale 1ns/1ns
module rpp_stage_test;
	localparam int TK = 50;
	logic               clk_in = 1'b0;
	logic               rst_in = 1'b1;
	logic               cyc = 1'b0;
	logic               we = 1'b0;
	logic [7:0]         adr = 8'h00;
	logic [31:0]        dat = 32'h0;
	logic [31:0]        rd;
	logic [31:0]        wb_dat_out;
	logic               wb_ack_out;
	logic signed [31:0] pwr_cmd = 32'sh0;
	logic               blk_cmd = 1'b0;
	logic [15:0]        mag;
	logic signed [31:0] pwr;
	logic               blk;
	logic               start_out, trip_out, blocked_out, evt_valid_out;
	logic [1:0]         cond_out;
	logic [2:0]         evt_code_out;
	logic [31:0]        evt_time_out;
	int                 num_errors = 0;
	int                 n_compared = 0;
	logic [29:0]        evt_seq = 30'h0;
	int                 n_evt = 0;
	logic [31:0]        evt_stamp = 32'h0;
	always #4 clk_in = ~clk_in;
	// event stream log
	always @(posedge clk_in)
	begin
		if (evt_valid_out === 1'b1)
		begin
			evt_seq <= {evt_seq[26:0], evt_code_out};
			n_evt <= n_evt + 1;
			evt_stamp <= evt_time_out;
		end
	end
	rpp_far_end rpp_far_end_i (.clk_in(clk_in), .pwr_cmd_in(pwr_cmd), .blk_cmd_in(blk_cmd),
		.mag_out(mag), .pwr_out(pwr), .blk_out(blk));
	rpp_stage #(.CYC_PER_MS(10)) rpp_stage_i (.clk_in(clk_in), .rst_in(rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'hF), .wb_dat_in(dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.i_l1_in(mag), .i_l2_in(mag), .i_l3_in(mag), .u1_in(mag), .u2_in(mag),
		.u3_in(mag), .u4_in(mag), .measured_active_power_in(pwr), .block_in(blk),
		.start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
		.cond_out(cond_out), .evt_valid_out(evt_valid_out), .evt_code_out(evt_code_out),
		.evt_time_out(evt_time_out));
	task stop_test;
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("unexpected %0t got %h want %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (wb_ack_out !== 1'b1 && n < 20);
		rd = wb_dat_out;
		if (n >= 20)
			chk(32'h0, 32'h1);
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task ticks(input int n);
		repeat (n * TK) @(posedge clk_in);
	endtask
	task outs(input logic s, input logic t, input logic b, input logic [1:0] c);
		@(posedge clk_in);
		chk({start_out, trip_out, blocked_out, cond_out}, {s, t, b, c});
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_in);
		num_errors++;
		stop_test();
	end
	initial
	begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rdc(8'h04, 32'h00002710);
		rdc(8'h08, 32'h000000C8);
		rdc(8'h2C, 32'h0000003F);
		rdc(8'h00, 32'h00000000);
		rdc(8'h3C, 32'h00000000);
		bus(1'b1, 8'h04, 32'h000003E8);
		bus(1'b1, 8'h08, 32'h00000003);
		bus(1'b1, 8'h0C, 32'h00000000);
		rdc(8'h08, 32'h00000003);
		pwr_cmd <= -32'sd1000;
		ticks(2);
		outs(1'b1, 1'b0, 1'b0, 2'h1);
		rdc(8'h14, 32'h00000064);
		rdc(8'h18, 32'h00000003);
		ticks(3);
		chk({trip_out, cond_out}, {1'b1, 2'h2});
		pwr_cmd <= -32'sd980;
		ticks(2);
		chk({trip_out, cond_out}, {1'b1, 2'h2});
		rdc(8'h14, 32'h00000062);
		pwr_cmd <= -32'sd960;
		ticks(2);
		outs(1'b0, 1'b0, 1'b0, 2'h0);
		rdc(8'h20, 32'h00000001);
		rdc(8'h24, 32'h00000001);
		bus(1'b1, 8'h20, 32'h0);
		rdc(8'h20, 32'h00000000);
		blk_cmd <= 1'b1;
		ticks(2);
		pwr_cmd <= -32'sd1000;
		ticks(2);
		outs(1'b0, 1'b0, 1'b1, 2'h3);
		rdc(8'h28, 32'h00000001);
		rdc(8'h1C, 32'h00000000);
		bus(1'b1, 8'h00, 32'h00000005);
		ticks(1);
		chk(cond_out, 2'h2);
		bus(1'b1, 8'h00, 32'h00000070);
		ticks(1);
		chk(cond_out, 2'h0);
		chk(n_evt, 32'h0000000A);
		chk({2'h0, evt_seq}, {2'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2, 3'h5, 3'h3, 3'h4, 3'h5});
		chk(evt_stamp, 32'h00000050);
		blk_cmd <= 1'b0;
		bus(1'b1, 8'h00, 32'h00000000);
		ticks(1);
		outs(1'b1, 1'b0, 1'b0, 2'h1);
		blk_cmd <= 1'b1;
		ticks(1);
		outs(1'b0, 1'b0, 1'b0, 2'h0);
		rdc(8'h1C, 32'h00000003);
		repeat (12)
		begin
			bus(1'b1, 8'h00, 32'h00000003);
			bus(1'b1, 8'h00, 32'h00000000);
		end
		rdc(8'h20, 32'h0000000D);
		stop_test();
	end
endmodule
